// ===== capture_filter.sv
// Noise canceller for the timer capture input.
// Assumes the input is already synchronised to clk.
`timescale 1ns/1ps
module capture_filter
	import port2_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic enable,
	input  wire logic din,
	output logic      dout
);
	logic [filter_len-1:0] hist_q;
	logic                  filt_q;

	// Shift history of the input
	always_ff @(posedge clk) begin
		if (srst) begin
			hist_q <= '0;
		end else begin
			hist_q <= {hist_q[filter_len-2:0], din};
		end
	end

	// Follow only a level that stayed stable for the whole window
	always_ff @(posedge clk) begin
		if (srst) begin
			filt_q <= 1'b0;
		end else if (&hist_q) begin
			filt_q <= 1'b1;
		end else if (~|hist_q) begin
			filt_q <= 1'b0;
		end
	end

	assign dout = enable ? filt_q : hist_q[0];
endmodule

// ===== port2_gpio.sv
// Port 2 general-purpose I/O with alternate pin function selection.
// Assumes an AHB-Lite master on clk and pins outside the clock domain.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module port2_gpio
	import port2_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// Port pins
	input  wire logic [7:0]             pin_in,
	output port2_pkg::pin_drive_type    pin_drive,
	// Alternate function hookups
	input  wire logic                   timer_capture_input,
	output logic                        timer_capture_filtered,
	output logic                        updown_in,
	output logic                        ext_int4_in,
	output logic                        conversion_trigger_input,
	output port2_pkg::alt_select_type   alt_select
);
	import port2_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0]    out_data_q;
	logic [7:0]    direction_q;
	logic [5:0]    mode_q;
	logic [7:0]    open_drain_q;
	logic [7:0]    pin_meta_q;
	logic [7:0]    pin_sync_q;
	logic          cap_meta_q;
	logic          cap_sync_q;
	logic          cap_filt;
	bus_state_type bus_q;
	logic [15:0]   addr_q;
	logic [7:0]    read_value;
	logic [7:0]    mode_read;
	logic [7:0]    alt_pin;
	logic [7:0]    pin_out_d;
	logic [7:0]    pin_oe_d;
	logic          take;

	// Byte address to register index
	function automatic logic [15:0] reg_index(input logic [31:0] a);
		reg_index = a[addr_width-1:2];
	endfunction

	// ==========================================================
	// Bus address phase capture
	assign take = hsel & hready & htrans[1];

	// Pipeline the address phase into the data phase
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_q  <= bus_idle;
			addr_q <= 16'h0000;
		end else if (hready) begin
			addr_q <= reg_index(haddr);
			if (!take) begin
				bus_q <= bus_idle;
			end else if (hwrite) begin
				bus_q <= bus_write;
			end else begin
				bus_q <= bus_read;
			end
		end
	end

	// ==========================================================
	// Data register
	always_ff @(posedge clk) begin
		if (srst) begin
			out_data_q <= rst_out_data;
		end else if (bus_q == bus_write && addr_q == idx_out_data) begin
			out_data_q <= hwdata[7:0];
		end
	end

	// Direction register
	always_ff @(posedge clk) begin
		if (srst) begin
			direction_q <= rst_direction;
		end else if (bus_q == bus_write && addr_q == idx_direction) begin
			direction_q <= hwdata[7:0];
		end
	end

	// Mode register, writable bits only
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q <= rst_alt_mode[5:0];
		end else if (bus_q == bus_write && addr_q == idx_alt_mode) begin
			mode_q <= hwdata[5:0];
		end
	end

	// Open-drain select register
	always_ff @(posedge clk) begin
		if (srst) begin
			open_drain_q <= rst_open_drain;
		end else if (bus_q == bus_write && addr_q == idx_open_drain) begin
			open_drain_q <= hwdata[7:0];
		end
	end

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_q <= 8'h00;
			pin_sync_q <= 8'h00;
			cap_meta_q <= 1'b0;
			cap_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
			cap_meta_q <= timer_capture_input;
			cap_sync_q <= cap_meta_q;
		end
	end

	capture_filter u_filter (
		.clk    (clk),
		.srst   (srst),
		.enable (mode_q[bit_cap_filter]),
		.din    (cap_sync_q),
		.dout   (cap_filt)
	);

	// ==========================================================
	// Read mux
	// reserved bits read one
	assign mode_read = mode_fixed | {2'b00, mode_q};

	always_comb begin
		read_value = 8'h00;
		case (addr_q)
			idx_out_data:   read_value = (direction_q & out_data_q)
			                           | (~direction_q & pin_sync_q);
			idx_direction:  read_value = dir_read_value;
			idx_alt_mode:   read_value = mode_read;
			idx_open_drain: read_value = open_drain_q;
			default:        read_value = 8'h00;
		endcase
	end

	// Load read data in the wait state so it stands at the closing edge
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= 32'h0000_0000;
		end else if (bus_q == bus_read && !hreadyout) begin
			hrdata <= {24'h00_0000, read_value};
		end
	end

	// ==========================================================
	// Pin drive
	// alternate pins released
	assign alt_pin = {6'b00_0000, mode_q[bit_updown], mode_q[bit_ext_int4]};

	always_comb begin
		pin_out_d = 8'h00;
		pin_oe_d  = 8'h00;
		for (int n = 0; n < 8; n++) begin
			if (alt_pin[n]) begin
				pin_oe_d[n] = 1'b0;
			end else if (direction_q[n]) begin
				if (open_drain_q[n]) begin
					pin_out_d[n] = 1'b0;
					pin_oe_d[n]  = ~out_data_q[n];
				end else begin
					pin_out_d[n] = out_data_q[n];
					pin_oe_d[n]  = 1'b1;
				end
			end
		end
	end

	// Registered pin and alternate outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_drive                <= '0;
			updown_in                <= 1'b0;
			ext_int4_in              <= 1'b0;
			conversion_trigger_input <= 1'b0;
			timer_capture_filtered   <= 1'b0;
			alt_select               <= '0;
			hreadyout                <= 1'b1;
			hresp                    <= 1'b0;
		end else begin
			pin_drive.out <= pin_out_d;
			pin_drive.oe  <= pin_oe_d;
			updown_in <= mode_q[bit_updown] & pin_sync_q[1];
			ext_int4_in <= mode_q[bit_ext_int4] & pin_sync_q[0];
			conversion_trigger_input <= mode_q[bit_ext_int4] & pin_sync_q[0];
			timer_capture_filtered   <= cap_filt;
			alt_select.serial_out2_pullup_off <= mode_q[bit_so2_pullup];
			alt_select.serial_out1_pullup_off <= mode_q[bit_so1_pullup];
			alt_select.ext_interrupt0_select  <= mode_q[bit_ext_int0];
			alt_select.updown_count_select    <= mode_q[bit_updown];
			alt_select.ext_interrupt4_select  <= mode_q[bit_ext_int4];
			alt_select.capture_filter_enable  <= mode_q[bit_cap_filter];
			// One wait state after each read address phase
			hreadyout <= !(take && !hwrite);
			hresp     <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	sequence dir_written;
		bus_q == bus_write && addr_q == idx_direction;
	endsequence

	dir_read_ones_a: assert property (@(posedge clk) disable iff (srst)
		bus_q == bus_read && !hreadyout && addr_q == idx_direction
		|=> hrdata == 32'hff)
		else $error("direction read not all ones");

	mode_fixed_a: assert property (@(posedge clk) disable iff (srst)
		bus_q == bus_read && !hreadyout && addr_q == idx_alt_mode
		|=> hrdata[7:6] == 2'b11)
		else $error("mode reserved bits not one");

	out_readback_a: assert property (@(posedge clk) disable iff (srst)
		bus_q == bus_read && !hreadyout && addr_q == idx_out_data
		|=> (hrdata[7:0] & direction_q) == (out_data_q & direction_q))
		else $error("output pin readback wrong");

	in_readback_a: assert property (@(posedge clk) disable iff (srst)
		bus_q == bus_read && !hreadyout && addr_q == idx_out_data
		|=> (hrdata[7:0] & ~$past(direction_q))
		    == ($past(pin_sync_q) & ~$past(direction_q)))
		else $error("input pin readback wrong");

	dir_drive_a: assert property (@(posedge clk) disable iff (srst)
		dir_written ##1 (direction_q == 8'h00 && mode_q[1:0] == 2'b00)
		|=> pin_drive.oe == 8'h00)
		else $error("input pin still driven");

	alt_release_a: assert property (@(posedge clk) disable iff (srst)
		mode_q[bit_updown] |=> !pin_drive.oe[1])
		else $error("alternate pin driven");

	od_low_a: assert property (@(posedge clk) disable iff (srst)
		direction_q[2] && open_drain_q[2] && !mode_q[1]
		|=> pin_drive.out[2] == 1'b0)
		else $error("open-drain pin drove high");

	od_release_a: assert property (@(posedge clk) disable iff (srst)
		direction_q[3] && open_drain_q[3] && out_data_q[3]
		|=> !pin_drive.oe[3])
		else $error("open-drain pin not released");

	reset_vals_a: assert property (@(posedge clk)
		srst |=> out_data_q == 8'h00 && direction_q == 8'h00
		         && open_drain_q == 8'h00 && mode_q == 6'h00)
		else $error("reset value wrong");

	// Read address phase accepted
	sequence read_taken;
		take && !hwrite;
	endsequence

	// Single wait state, then ready again
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	// Reads hold the bus one cycle so hrdata is settled when sampled
	read_wait_a: assert property (@(posedge clk) disable iff (srst)
		read_taken |=> one_wait)
		else $error("read wait state missing");

	// Data writes land at the end of the data phase
	data_write_a: assert property (@(posedge clk) disable iff (srst)
		bus_q == bus_write && addr_q == idx_out_data
		|=> out_data_q == $past(hwdata[7:0]))
		else $error("data write lost");

	// Push-pull output pin drives its data bit
	push_pull_a: assert property (@(posedge clk) disable iff (srst)
		direction_q[4] && !open_drain_q[4]
		|=> pin_drive.oe[4] && pin_drive.out[4] == $past(out_data_q[4]))
		else $error("push-pull pin drive wrong");

	// Up/down input follows synced pin 1
	updown_follow_a: assert property (@(posedge clk) disable iff (srst)
		mode_q[bit_updown] |=> updown_in == $past(pin_sync_q[1]))
		else $error("up/down input wrong");

	// Interrupt 4 and trigger inputs follow synced pin 0
	int4_follow_a: assert property (@(posedge clk) disable iff (srst)
		mode_q[bit_ext_int4]
		|=> ext_int4_in == $past(pin_sync_q[0])
		    && conversion_trigger_input == $past(pin_sync_q[0]))
		else $error("interrupt four input wrong");

	// Serial out two buffer select mirrors its mode bit
	so2_export_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> alt_select.serial_out2_pullup_off
		    == $past(mode_q[bit_so2_pullup]))
		else $error("serial out two select wrong");

	// Serial out one buffer select mirrors its mode bit
	so1_export_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> alt_select.serial_out1_pullup_off
		    == $past(mode_q[bit_so1_pullup]))
		else $error("serial out one select wrong");

	// Interrupt 0 pin select mirrors its mode bit
	int0_export_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> alt_select.ext_interrupt0_select
		    == $past(mode_q[bit_ext_int0]))
		else $error("interrupt zero select wrong");
endmodule

// ===== port2_gpio_tb_top.sv
// Self-checking bench for the port 2 GPIO block.
// Assumes the port2_pkg register map and a single AHB-Lite slave on clk.
`timescale 1ns/1ps
module port2_gpio_tb_top;
	import port2_pkg::*;
	logic          clk, srst, hsel, hwrite, hready, tci;
	logic [31:0]   haddr, hwdata, hrdata;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [7:0]    pin_in;
	logic          hreadyout, hresp, tcf, ud_in, i4_in, adc_in;
	pin_drive_type pin_drive;
	alt_select_type alt_select;
	int            err_total, check_count;
	logic [31:0]   rv;
	logic [7:0]    dv, pv, dr, od, mv;

	assign hready = hreadyout;
	port2_gpio u_port2_gpio (.clk(clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
		.pin_drive(pin_drive), .timer_capture_input(tci),
		.timer_capture_filtered(tcf), .updown_in(ud_in),
		.ext_int4_in(i4_in), .conversion_trigger_input(adc_in),
		.alt_select(alt_select));

	// ==========================================================
	// Clock and reporting
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim;
		if (err_total == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] adr(input logic [15:0] idx);
		return {14'h0000, idx, 2'b00};
	endfunction

	// ==========================================================
	// Bus master: address phase held until hready, then data phase
	task automatic xfer(input logic w, input logic [15:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		haddr  <= adr(idx);
		htrans <= 2'b10;
		hwrite <= w;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 16);
		if (n >= 16) begin err_total++; end_sim(); end
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 16);
		if (n >= 16) begin err_total++; end_sim(); end
		rd = hrdata;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] x;
		xfer(1'b1, idx, d, x);
	endtask

	// Pins follow a write one cycle later and inputs pass two flops
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	task automatic do_reset;
		srst <= 1'b1;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		err_total = 0; check_count = 0;
		srst = 1'b1; hsel = 1'b1; hwrite = 1'b0; htrans = 2'b00;
		haddr = 32'h0; hwdata = 32'h0; hsize = 3'b010;
		pin_in = 8'h00; tci = 1'b0;
		void'($urandom(49675));
		do_reset();
		chk("oe_rst", 32'h0, pin_drive.oe);
		chk("alt_rst", 32'h0, alt_select);
		xfer(1'b0, idx_alt_mode, 8'h00, rv); chk("mode_rst", 32'hc0, rv);
		xfer(1'b0, idx_open_drain, 8'h00, rv); chk("od_rst", 32'h0, rv);
		xfer(1'b0, idx_direction, 8'h00, rv); chk("dir_rd", 32'hff, rv);
		wr(idx_direction, 8'hff); settle();
		xfer(1'b0, idx_out_data, 8'h00, rv); chk("data_rst", 32'h0, rv);
		// Unmapped place: write ignored, read zero
		wr(16'h0100, 8'h5a);
		xfer(1'b0, 16'h0100, 8'h00, rv); chk("unmapped", 32'h0, rv);
		// Mode register: fixed top bits, fields exported
		for (int i = 0; i < 12; i++) begin
			mv = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			wr(idx_alt_mode, mv);
			xfer(1'b0, idx_alt_mode, 8'h00, rv);
			chk("mode_rd", {24'h0, mv | 8'hc0}, rv);
			chk("so2_off", mv[5], alt_select.serial_out2_pullup_off);
			chk("so1_off", mv[2], alt_select.serial_out1_pullup_off);
			chk("filt_en", mv[4], alt_select.capture_filter_enable);
			chk("int0_sel", mv[3], alt_select.ext_interrupt0_select);
			chk("ud_sel", mv[1], alt_select.updown_count_select);
			chk("int4_sel", mv[0], alt_select.ext_interrupt4_select);
		end
		wr(idx_alt_mode, 8'h00);
		// Random general-purpose traffic, corners first
		for (int i = 0; i < 24; i++) begin
			dr = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			dv = 8'($urandom); od = (i < 2) ? 8'h00 : 8'($urandom);
			pv = ~dv;
			pin_in <= pv;
			wr(idx_direction, dr); wr(idx_out_data, dv); wr(idx_open_drain, od);
			settle();
			xfer(1'b0, idx_out_data, 8'h00, rv);
			chk("read_mix", {24'h0, (dr & dv) | (~dr & pv)}, rv);
			chk("oe", {24'h0, dr & ~(od & dv)}, pin_drive.oe);
			chk("out", {24'h0, dv & ~od & dr}, pin_drive.out & dr);
			xfer(1'b0, idx_open_drain, 8'h00, rv); chk("od_rd", {24'h0, od}, rv);
			xfer(1'b0, idx_direction, 8'h00, rv); chk("dir_wo", 32'hff, rv);
		end
		// Alternate functions on pins 0 and 1 take over the drivers
		wr(idx_open_drain, 8'h00); wr(idx_direction, 8'hff); wr(idx_out_data, 8'hff);
		wr(idx_alt_mode, 8'h03);
		for (int i = 0; i < 4; i++) begin
			pin_in <= 8'(i);
			settle();
			chk("alt_oe", 32'h0, pin_drive.oe[1:0]);
			chk("gpio_oe", 32'hfc, pin_drive.oe & 8'hfc);
			chk("ud_in", i[1], ud_in);
			chk("int4_in", i[0], i4_in);
			chk("trig_in", i[0], adc_in);
		end
		wr(idx_alt_mode, 8'h00); settle();
		chk("gpio_back", 32'h3, pin_drive.oe[1:0]);
		// Capture filter: pass-through when off, glitch removal when on
		tci <= 1'b1; settle(); settle();
		chk("filt_off", 32'h1, tcf);
		wr(idx_alt_mode, 8'h10); settle(); settle();
		tci <= 1'b0; @(posedge clk); tci <= 1'b1;
		// Unfiltered, the glitch would reach tcf exactly here
		repeat (4) @(posedge clk);
		chk("filt_glitch", 32'h1, tcf);
		repeat (4) @(posedge clk);
		chk("filt_after", 32'h1, tcf);
		tci <= 1'b0; repeat (5) @(posedge clk);
		chk("filt_hold", 32'h1, tcf);
		repeat (7) @(posedge clk);
		chk("filt_steady", 32'h0, tcf);
		// Second reset in mid-run clears data and direction
		wr(idx_out_data, 8'ha5);
		do_reset();
		chk("oe_rst2", 32'h0, pin_drive.oe);
		wr(idx_direction, 8'hff); settle();
		xfer(1'b0, idx_out_data, 8'h00, rv); chk("data_rst2", 32'h0, rv);
		chk("out_rst2", 32'h0, pin_drive.out);
		chk("hresp", 32'h0, hresp);
		end_sim();
	end
endmodule

// ===== port2_pkg.sv
// Port 2 package: register map, field positions, reset values, carriers.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package port2_pkg;

	// ==========================================================
	// Register indices as printed, byte address is four times these
	localparam logic [15:0] idx_alt_mode   = 16'hffc9;
	localparam logic [15:0] idx_open_drain = 16'hffcb;
	localparam logic [15:0] idx_out_data   = 16'hffd5;
	localparam logic [15:0] idx_direction  = 16'hffe5;
	localparam int          addr_width     = 18;

	// ==========================================================
	// Reset values
	localparam logic [7:0] rst_alt_mode   = 8'hc0;
	localparam logic [7:0] rst_open_drain = 8'h00;
	localparam logic [7:0] rst_out_data   = 8'h00;
	localparam logic [7:0] rst_direction  = 8'h00;
	localparam logic [7:0] dir_read_value = 8'hff;
	localparam logic [7:0] mode_fixed     = 8'hc0;

	// ==========================================================
	// Mode register field positions
	localparam int bit_ext_int4   = 0;
	localparam int bit_updown     = 1;
	localparam int bit_so1_pullup = 2;
	localparam int bit_ext_int0   = 3;
	localparam int bit_cap_filter = 4;
	localparam int bit_so2_pullup = 5;

	// ==========================================================
	// Capture filter timing
	localparam int filter_len = 4;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_type;

	typedef struct packed {
		logic serial_out1_pullup_off;
		logic serial_out2_pullup_off;
		logic ext_interrupt0_select;
		logic updown_count_select;
		logic ext_interrupt4_select;
		logic capture_filter_enable;
	} alt_select_type;

	typedef enum logic [1:0] {
		bus_idle  = 2'b00,
		bus_write = 2'b01,
		bus_read  = 2'b10
	} bus_state_type;

endpackage
